// ===== src/kms_consts.svh
/*
  Named constants of the key matrix scanner: register offsets, field ranges,
  reset values and sizes. Guarded, so it may be included more than once per compile unit.
*/
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH

// register byte offsets on the apb slave
`define KMS_ADDR_CTRL 8'h00
`define KMS_ADDR_TIMING 8'h04
`define KMS_ADDR_DEBOUNCE 8'h08
`define KMS_ADDR_STATUS 8'h0c
`define KMS_ADDR_DIMS 8'h10
`define KMS_ADDR_EVENT 8'h14

// scanner_control fields
`define KMS_CTRL_EN 0
`define KMS_CTRL_IDLE_EN 1
`define KMS_CTRL_QCLR 2
`define KMS_CTRL_QF_IE 3
`define KMS_CTRL_NE_IE 4
`define KMS_CTRL_IDLE_LIM 15:8
`define KMS_CTRL_DIV 23:16
`define KMS_CTRL_SRC 24

// row_timing_control, debounce_limits, matrix_dimensions fields
`define KMS_TIM_SETTLE 9:0
`define KMS_DEB_PRESS 6:0
`define KMS_DEB_REL 14:8
`define KMS_DIM_ROWS 3:0
`define KMS_DIM_COLS 12:8

// scanner_state_report fields
`define KMS_ST_NEW 0
`define KMS_ST_UNF 1
`define KMS_ST_OVF 2
`define KMS_ST_IDLE 3
`define KMS_ST_COUNT 7:4
`define KMS_ST_ACT 8
`define KMS_ST_RUN 9

// event word layout
`define KMS_EV_LAST 10
`define KMS_EV_STATE 9
`define KMS_EV_COL 8:4
`define KMS_EV_ROW 3:0
`define KMS_FINAL_WORD 11'h7ff

// reset values
`define KMS_DEB_RESET 7'h01
`define KMS_SETTLE_RESET 10'h001
`define KMS_IDLE_RESET 8'h10
`define KMS_DIV_RESET 8'h00
`define KMS_DIMS_ROWS_RESET 4'hf
`define KMS_DIMS_COLS_RESET 5'h1f
`define KMS_ROW_IDLE 16'hffff
`define KMS_ROW_ONE 16'h0001
`define KMS_COL_IDLE 32'hffffffff
`define KMS_CNT_MAX 7'h7f

// sizes
`define KMS_ROWS 16
`define KMS_COLS 32
`define KMS_SLOTS 12
`define KMS_LAST_SLOT 4'hb
`define KMS_FIFO_DEPTH 12
`define KMS_FIFO_LAST 4'hb
`define KMS_FIFO_FULL 4'hc

`endif

// ===== src/key_scan_pkg.sv
/*
  Types shared by the key matrix scanner modules.
  Assumes nothing of its surroundings.
*/
package key_scan_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_ROW, ST_DEB, ST_EMIT, ST_FINAL, ST_CHECK, ST_HALT}
    scan_state_t;
  typedef logic [10:0] event_word_t;
endpackage

// ===== src/skid_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module skid_buffer (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic clear, // drop both entries
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire key_scan_pkg::event_word_t in_data, // offered word
  output logic out_valid, // word available
  input wire logic out_ready, // sink takes word
  output key_scan_pkg::event_word_t out_data // oldest word
);
  import key_scan_pkg::*;
  event_word_t spare;
  logic [1:0] fill;
  logic take;
  logic give;

  // handshakes are combinational from the fill level
  assign in_ready = (fill != 2'd2);
  assign out_valid = (fill != 2'd0);
  assign take = in_valid & in_ready;
  assign give = out_valid & out_ready;

  // head and spare shift together so out_data always comes from a flop
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      fill <= 2'd0;
      out_data <= '0;
      spare <= '0;
    end else if (take && !give) begin
      if (fill == 2'd0) begin
        out_data <= in_data;
      end else begin
        spare <= in_data;
      end
      fill <= fill + 2'd1;
    end else if (give && !take) begin
      out_data <= spare;
      fill <= fill - 2'd1;
    end else if (give && take) begin
      if (fill == 2'd1) begin
        out_data <= in_data;
      end else begin
        out_data <= spare;
        spare <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/event_fifo.sv
/*
  Twelve-word event queue read by software one word per access.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "kms_consts.svh"
module event_fifo (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic clear, // discard all words
  input wire logic push, // write a word
  input wire key_scan_pkg::event_word_t push_data, // word to write
  input wire logic pop, // remove the head
  output key_scan_pkg::event_word_t head, // oldest word
  output logic [3:0] count, // words held
  output logic full, // no room
  output logic empty // nothing held
);
  import key_scan_pkg::*;
  event_word_t mem [`KMS_FIFO_DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign full = (count == `KMS_FIFO_FULL);
  assign empty = (count == 4'h0);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign head = mem[rd_ptr];

  // storage has no reset; only pointers decide what is valid
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // pointers wrap at the last entry rather than at a power of two
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 4'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == `KMS_FIFO_LAST) ? 4'h0 : wr_ptr + 4'h1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == `KMS_FIFO_LAST) ? 4'h0 : rd_ptr + 4'h1;
      end
      count <= count + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule
`default_nettype wire

// ===== src/key_matrix_scanner.sv
/*
  Key matrix scanner: row drive, column sampling, twelve debounce slots,
  event queue, interrupt and apb register file.
  Assumes columns are pulled up, rows are open outputs, one 125 MHz clock.
*/
// Functional notes
// RULE1 - drive one row low, wait settle time, sample columns, every row
// RULE2 - activity flag follows sensed presses and any debounce in progress
// RULE3 - after a full scan, debounce slots step once per scan to limit
// RULE4 - idle stop enabled halts after idle limit of quiet scan cycles
// RULE5 - idle stop disabled keeps scanning without end
// RULE6 - each scan with events writes one word per event into the queue
// RULE7 - word bit 9 key state, bits 8:4 column, bits 3:0 row
// RULE8 - bit 10 marks the scan's final word, all other bits high
// RULE9 - interrupt on new queue word, queue fault, or idle elapsed
// RULE10 - status shows interrupt causes and words held in the queue
// RULE11 - writing the queue clear bit discards every stored word
// RULE12 - a scan takes rows times settle clocks plus two scan clocks
// RULE13 - settle time counts scan clock cycles before sampling
// RULE14 - separate press and release limits, both resetting to one
// RULE15 - queue holds twelve words, each read returns the oldest
// RULE16 - source select zero derives the scan clock through the divider
// RULE17 - software enables both interrupts and sets scanner enable last
// RULE18 - once enabled, scanning and debouncing need no software help
// RULE19 - up to sixteen rows and thirty-two columns
// RULE20 - debounce counters are seven bits and count scan cycles
// RULE21 - software sets row and column roles and size before enabling
// RULE22 - overflow drops the new word; empty read flags underflow only
// RULE23 - clearing enable stops scan, releases rows, clears debounce state
`timescale 1ns/1ns
`default_nettype none
`include "kms_consts.svh"
module key_matrix_scanner (
  input wire logic clock, // 125 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on an address above the event register at 8'h14
  output logic [15:0] row_drive_n, // row drives, low selects the row
  input wire logic [31:0] col_in, // column pins, low means key closed
  output logic irq // interrupt request, active high
);
  import key_scan_pkg::*;

  scan_state_t state;
  logic scanner_enable, idle_stop_enable, queue_fault_irq_enable, new_event_irq_enable;
  logic scan_clock_source_select;
  logic [7:0] idle_cycle_limit, scan_clock_divider, div_cnt, idle_cnt;
  logic [9:0] row_settle_time;
  logic [6:0] press_limit, release_limit;
  logic [3:0] rows_m1, row_idx, emit_idx, alloc_slot, fifo_count;
  logic [4:0] cols_m1, alloc_col;
  logic [10:0] phase;
  logic [31:0] col_s1, col_s2, col_s3, col_clean, col_mask, tracked, diff, cand;
  logic [31:0] stable_mem [`KMS_ROWS];
  logic [31:0] sample_mem [`KMS_ROWS];
  logic [`KMS_SLOTS-1:0] slot_valid, slot_done;
  logic [3:0] slot_row [`KMS_SLOTS];
  logic [4:0] slot_col [`KMS_SLOTS];
  logic [6:0] slot_cnt [`KMS_SLOTS];
  logic tick, sample_now, have_free, have_cand, alloc_fire, scan_seen, any_event, key_stat;
  logic emit_valid, emit_drop, emit_take, skid_in_ready, skid_out_valid, fifo_full, fifo_empty;
  logic new_flag, unf_flag, ovf_flag, idle_flag, queue_clear, ev_read, apb_wr, st_wr;
  event_word_t emit_word, skid_word, fifo_head;

  assign apb_wr = psel & penable & pwrite;
  assign st_wr = apb_wr & (paddr == `KMS_ADDR_STATUS);
  assign ev_read = psel & penable & ~pwrite & (paddr == `KMS_ADDR_EVENT);
  assign queue_clear = apb_wr & (paddr == `KMS_ADDR_CTRL) & pwdata[`KMS_CTRL_QCLR]; // see RULE11
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > `KMS_ADDR_EVENT);

  // writable configuration; registers keep their value across disable
  always_ff @(posedge clock) begin
    if (rst) begin
      scanner_enable <= 1'b0;
      idle_stop_enable <= 1'b0;
      queue_fault_irq_enable <= 1'b0;
      new_event_irq_enable <= 1'b0;
      idle_cycle_limit <= `KMS_IDLE_RESET;
      scan_clock_divider <= `KMS_DIV_RESET;
      scan_clock_source_select <= 1'b0;
      row_settle_time <= `KMS_SETTLE_RESET;
      press_limit <= `KMS_DEB_RESET; // see RULE14
      release_limit <= `KMS_DEB_RESET;
      rows_m1 <= `KMS_DIMS_ROWS_RESET;
      cols_m1 <= `KMS_DIMS_COLS_RESET;
    end else if (apb_wr) begin
      unique case (paddr)
        `KMS_ADDR_CTRL: begin
          scanner_enable <= pwdata[`KMS_CTRL_EN];
          idle_stop_enable <= pwdata[`KMS_CTRL_IDLE_EN];
          queue_fault_irq_enable <= pwdata[`KMS_CTRL_QF_IE];
          new_event_irq_enable <= pwdata[`KMS_CTRL_NE_IE];
          idle_cycle_limit <= pwdata[`KMS_CTRL_IDLE_LIM];
          scan_clock_divider <= pwdata[`KMS_CTRL_DIV];
          scan_clock_source_select <= pwdata[`KMS_CTRL_SRC];
        end
        `KMS_ADDR_TIMING: row_settle_time <= pwdata[`KMS_TIM_SETTLE];
        `KMS_ADDR_DEBOUNCE: begin
          press_limit <= pwdata[`KMS_DEB_PRESS];
          release_limit <= pwdata[`KMS_DEB_REL];
        end
        `KMS_ADDR_DIMS: begin
          rows_m1 <= pwdata[`KMS_DIM_ROWS]; // see RULE19
          cols_m1 <= pwdata[`KMS_DIM_COLS];
        end
        default: ;
      endcase
    end
  end

  // read data is latched in the setup phase so it comes from flops
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      unique case (paddr)
        `KMS_ADDR_CTRL: begin
          prdata[`KMS_CTRL_EN] <= scanner_enable;
          prdata[`KMS_CTRL_IDLE_EN] <= idle_stop_enable;
          prdata[`KMS_CTRL_QF_IE] <= queue_fault_irq_enable;
          prdata[`KMS_CTRL_NE_IE] <= new_event_irq_enable;
          prdata[`KMS_CTRL_IDLE_LIM] <= idle_cycle_limit;
          prdata[`KMS_CTRL_DIV] <= scan_clock_divider;
          prdata[`KMS_CTRL_SRC] <= scan_clock_source_select;
        end
        `KMS_ADDR_TIMING: prdata[`KMS_TIM_SETTLE] <= row_settle_time;
        `KMS_ADDR_DEBOUNCE: begin
          prdata[`KMS_DEB_PRESS] <= press_limit;
          prdata[`KMS_DEB_REL] <= release_limit;
        end
        `KMS_ADDR_STATUS: begin
          prdata[`KMS_ST_NEW] <= new_flag; // see RULE10
          prdata[`KMS_ST_UNF] <= unf_flag;
          prdata[`KMS_ST_OVF] <= ovf_flag;
          prdata[`KMS_ST_IDLE] <= idle_flag;
          prdata[`KMS_ST_COUNT] <= fifo_count;
          prdata[`KMS_ST_ACT] <= key_stat;
          prdata[`KMS_ST_RUN] <= (state != ST_OFF) && (state != ST_HALT);
        end
        `KMS_ADDR_DIMS: begin
          prdata[`KMS_DIM_ROWS] <= rows_m1;
          prdata[`KMS_DIM_COLS] <= cols_m1;
        end
        `KMS_ADDR_EVENT: prdata[10:0] <= fifo_head; // see RULE15
        default: ;
      endcase
    end
  end

  // sticky causes, write one to clear; a same-cycle event wins the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      new_flag <= 1'b0;
      unf_flag <= 1'b0;
      ovf_flag <= 1'b0;
      idle_flag <= 1'b0;
    end else begin
      new_flag <= (new_flag & ~(st_wr & pwdata[`KMS_ST_NEW])) | (skid_out_valid & ~fifo_full);
      unf_flag <= (unf_flag & ~(st_wr & pwdata[`KMS_ST_UNF])) | (ev_read & fifo_empty); // see RULE22
      ovf_flag <= (ovf_flag & ~(st_wr & pwdata[`KMS_ST_OVF])) | (emit_valid & emit_drop);
      idle_flag <= (idle_flag & ~(st_wr & pwdata[`KMS_ST_IDLE])) |
                   ((state == ST_CHECK) && idle_stop_enable && !key_stat &&
                    (idle_cnt + 8'h01 >= idle_cycle_limit));
    end
  end

  // interrupt: idle elapsed is always reported
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (new_flag & new_event_irq_enable) | ((unf_flag | ovf_flag) & queue_fault_irq_enable)
             | idle_flag; // see RULE9
    end
  end

  // scan clock tick; the divider sets the period at divider plus one clocks
  assign tick = scan_clock_source_select ? 1'b1 : (div_cnt == scan_clock_divider); // see RULE16
  always_ff @(posedge clock) begin
    if (rst || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // columns pass three flops; a bit moves only when the last two agree
  always_ff @(posedge clock) begin
    if (rst) begin
      col_s1 <= `KMS_COL_IDLE;
      col_s2 <= `KMS_COL_IDLE;
      col_s3 <= `KMS_COL_IDLE;
      col_clean <= `KMS_COL_IDLE;
    end else begin
      col_s1 <= col_in;
      col_s2 <= col_s1;
      col_s3 <= col_s2;
      col_clean <= (~(col_s2 ^ col_s3) & col_s3) | ((col_s2 ^ col_s3) & col_clean);
    end
  end

  // row phase runs settle plus two ticks; the last one samples
  assign sample_now = (state == ST_ROW) && tick &&
                      (phase == {1'b0, row_settle_time} + 11'h001); // see RULE12 RULE13
  assign col_mask = `KMS_COL_IDLE >> (5'd31 - cols_m1);

  // new candidate and free slot; one allocation per sampled row
  always_comb begin
    tracked = '0;
    alloc_slot = 4'h0;
    have_free = 1'b0;
    alloc_col = 5'h00;
    have_cand = 1'b0;
    for (int i = 0; i < `KMS_SLOTS; i++) begin
      if (slot_valid[i] && slot_row[i] == row_idx) begin
        tracked[slot_col[i]] = 1'b1;
      end
    end
    diff = (col_clean ^ stable_mem[row_idx]) & col_mask;
    cand = diff & ~tracked;
    for (int i = `KMS_SLOTS - 1; i >= 0; i--) begin
      if (!slot_valid[i]) begin
        alloc_slot = 4'(i);
        have_free = 1'b1;
      end
    end
    for (int c = `KMS_COLS - 1; c >= 0; c--) begin
      if (cand[c]) begin
        alloc_col = 5'(c);
        have_cand = 1'b1;
      end
    end
  end
  assign alloc_fire = sample_now & have_cand & have_free;
  assign key_stat = scan_seen | (|slot_valid); // see RULE2

  // debounce slots; counters step once per completed scan
  for (genvar g = 0; g < `KMS_SLOTS; g++) begin : g_slot
    logic key_now, was_released;
    logic [6:0] lim, cnt_inc;
    assign key_now = sample_mem[slot_row[g]][slot_col[g]];
    assign was_released = stable_mem[slot_row[g]][slot_col[g]];
    assign lim = was_released ? press_limit : release_limit;
    assign cnt_inc = (slot_cnt[g] == `KMS_CNT_MAX) ? slot_cnt[g] : slot_cnt[g] + 7'h01;
    always_ff @(posedge clock) begin
      if (rst || !scanner_enable) begin
        slot_valid[g] <= 1'b0; // see RULE23
        slot_done[g] <= 1'b0;
        slot_row[g] <= 4'h0;
        slot_col[g] <= 5'h00;
        slot_cnt[g] <= 7'h00;
      end else if (alloc_fire && alloc_slot == 4'(g)) begin
        slot_valid[g] <= 1'b1;
        slot_done[g] <= 1'b0;
        slot_row[g] <= row_idx;
        slot_col[g] <= alloc_col;
        slot_cnt[g] <= 7'h00;
      end else if (state == ST_DEB && slot_valid[g] && !slot_done[g]) begin
        if (key_now == was_released) begin
          slot_valid[g] <= 1'b0; // bounced back, forget it
        end else begin
          slot_cnt[g] <= cnt_inc; // see RULE3 RULE20
          slot_done[g] <= (cnt_inc >= lim);
        end
      end else if (state == ST_EMIT && emit_take && emit_idx == 4'(g)) begin
        slot_valid[g] <= 1'b0;
        slot_done[g] <= 1'b0;
      end
    end
  end

  // key state memory; an emitted event commits the new state even if dropped
  always_ff @(posedge clock) begin
    if (rst || !scanner_enable) begin
      for (int r = 0; r < `KMS_ROWS; r++) begin
        stable_mem[r] <= `KMS_COL_IDLE;
      end
    end else if (state == ST_EMIT && emit_take) begin
      stable_mem[slot_row[emit_idx]][slot_col[emit_idx]] <=
        ~stable_mem[slot_row[emit_idx]][slot_col[emit_idx]];
    end
  end
  always_ff @(posedge clock) begin
    if (sample_now) begin
      sample_mem[row_idx] <= col_clean; // see RULE1
    end
  end

  // emitter feeds the buffer; a full buffer over a full queue drops the word
  assign emit_valid = (state == ST_EMIT && slot_done[emit_idx]) || state == ST_FINAL;
  assign emit_drop = ~skid_in_ready & fifo_full; // see RULE22
  assign emit_take = emit_valid & (skid_in_ready | emit_drop);
  always_comb begin
    emit_word = `KMS_FINAL_WORD; // see RULE8
    if (state != ST_FINAL) begin
      emit_word[`KMS_EV_LAST] = 1'b0;
      emit_word[`KMS_EV_STATE] = ~stable_mem[slot_row[emit_idx]][slot_col[emit_idx]]; // see RULE7
      emit_word[`KMS_EV_COL] = slot_col[emit_idx];
      emit_word[`KMS_EV_ROW] = slot_row[emit_idx];
    end
  end

  // scan sequencer
  always_ff @(posedge clock) begin
    if (rst || !scanner_enable) begin
      state <= ST_OFF; // see RULE23
      row_idx <= 4'h0;
      phase <= 11'h000;
      emit_idx <= 4'h0;
      any_event <= 1'b0;
      scan_seen <= 1'b0;
      idle_cnt <= 8'h00;
    end else begin
      unique case (state)
        ST_OFF: begin
          state <= ST_ROW; // see RULE18
          row_idx <= 4'h0;
          phase <= 11'h000;
          scan_seen <= 1'b0;
        end
        ST_ROW: begin
          if (sample_now) begin
            scan_seen <= scan_seen | (|diff);
            phase <= 11'h000;
            if (row_idx == rows_m1) begin
              state <= ST_DEB;
            end else begin
              row_idx <= row_idx + 4'h1;
            end
          end else if (tick) begin
            phase <= phase + 11'h001;
          end
        end
        ST_DEB: begin
          state <= ST_EMIT;
          emit_idx <= 4'h0;
          any_event <= 1'b0;
        end
        ST_EMIT: begin
          if (!slot_done[emit_idx] || emit_take) begin
            any_event <= any_event | emit_take; // see RULE6
            if (emit_idx == `KMS_LAST_SLOT) begin
              state <= (any_event || emit_take) ? ST_FINAL : ST_CHECK;
            end else begin
              emit_idx <= emit_idx + 4'h1;
            end
          end
        end
        ST_FINAL: begin
          if (emit_take) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          idle_cnt <= key_stat ? 8'h00 : idle_cnt + 8'h01;
          if (idle_stop_enable && !key_stat && (idle_cnt + 8'h01 >= idle_cycle_limit)) begin
            state <= ST_HALT; // see RULE4
          end else begin
            state <= ST_ROW; // see RULE5
            row_idx <= 4'h0;
            scan_seen <= 1'b0;
          end
        end
        ST_HALT: ;
      endcase
    end
  end

  // rows idle high outside a row phase
  always_ff @(posedge clock) begin
    if (rst) begin
      row_drive_n <= `KMS_ROW_IDLE;
    end else begin
      row_drive_n <= (state == ST_ROW) ? ~(`KMS_ROW_ONE << row_idx) : `KMS_ROW_IDLE; // see RULE1
    end
  end

  skid_buffer u_skid (
    .clock(clock),
    .rst(rst),
    .clear(queue_clear),
    .in_valid(emit_valid),
    .in_ready(skid_in_ready),
    .in_data(emit_word),
    .out_valid(skid_out_valid),
    .out_ready(~fifo_full),
    .out_data(skid_word)
  );

  event_fifo u_fifo (
    .clock(clock),
    .rst(rst),
    .clear(queue_clear),
    .push(skid_out_valid),
    .push_data(skid_word),
    .pop(ev_read),
    .head(fifo_head),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence enable_drop_s;
    scanner_enable ##1 !scanner_enable;
  endsequence

  one_row_low_a: assert property ($countones(~row_drive_n) <= 1) // see RULE1
    else $error("more than one row driven");
  row_release_a: assert property (enable_drop_s |=> ##1 row_drive_n == `KMS_ROW_IDLE) // see RULE23
    else $error("rows not released after disable");
  activity_flag_a: assert property (state == ST_DEB && |(slot_valid & slot_done) |=> key_stat) // see RULE2
    else $error("activity flag low during debounce");
  queue_depth_a: assert property (fifo_count <= `KMS_FIFO_FULL) // see RULE15
    else $error("queue count above depth");
  final_word_a: assert property (state == ST_FINAL |-> emit_word == `KMS_FINAL_WORD) // see RULE8
    else $error("final marker word malformed");
  overflow_flag_a: assert property (emit_valid && emit_drop |=> ovf_flag) // see RULE22
    else $error("dropped word not flagged");
  underflow_keep_a: assert property (ev_read && fifo_empty && !skid_out_valid
    |=> unf_flag && fifo_count == 4'h0) // see RULE22
    else $error("empty read mishandled");
  idle_halt_a: assert property (state == ST_CHECK && !idle_stop_enable |=> state != ST_HALT) // see RULE5
    else $error("halted with idle stop off");
  new_event_irq_a: assert property (skid_out_valid && !fifo_full && new_event_irq_enable
    ##1 new_event_irq_enable |=> irq) // see RULE9
    else $error("no interrupt for new word");
endmodule
`default_nettype wire

// ===== tb/key_matrix_model.sv
/* switch matrix model: one switch joins a row to a column.
   assumes pulled-up columns and rows driven low when selected. */
`timescale 1ns/1ns
`default_nettype none
module key_matrix_model (
  input wire logic [15:0] row_drive_n, // row drives
  input wire logic [3:0] key_row, // switch row
  input wire logic [4:0] key_col, // switch column
  input wire logic key_down, // switch closed
  output logic [31:0] col_in // columns
);
  // open columns sit at the pull-up level
  assign col_in = ~({31'h0, key_down && !row_drive_n[key_row]} << key_col);
endmodule
`default_nettype wire

// ===== tb/key_matrix_scanner_tb.sv
/* scanner bench: apb tasks and hand-written key scenarios.
   assumes the switch model drives the columns. */
`timescale 1ns/1ns
`default_nettype none
module key_matrix_scanner_tb;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, key_down = 0;
  logic irq, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, col_in, q;
  logic [15:0] row_drive_n;
  logic [3:0] key_row = 4'h0;
  logic [4:0] key_col = 5'h00;
  int error_cnt = 0, tests_run = 0;
  // 8 ns period
  always #4 clock = ~clock;
  key_matrix_scanner i_key_matrix_scanner (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .row_drive_n, .col_in, .irq);
  key_matrix_model i_key_matrix_model (.row_drive_n, .key_row, .key_col, .key_down, .col_in);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  // zero-wait transfer; data and error are taken at the access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    {e, q} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // move the switch, wait for the interrupt, let the queue settle
  task automatic key(input logic [3:0] r, input logic [4:0] c, input logic d);
    int n;
    {key_row, key_col, key_down} <= {r, c, d};
    // a just-cleared cause needs two edges before irq drops
    repeat (2) @(posedge clock);
    n = 0;
    while (n < 2000 && irq !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    chk("irq", {31'h0, irq}, 32'h1);
    repeat (20) @(posedge clock);
  endtask
  // reset values, then an unmapped address
  task automatic t_reset();
    rd(8'h08);
    chk("debounce", q, 32'h101);
    rd(8'h04);
    chk("settle", q, 32'h1);
    rd(8'h10);
    chk("dims", q, 32'h1f0f);
    rd(8'h18);
    chk("pslverr", {31'h0, e}, 32'h1);
    chk("pready", {31'h0, pready}, 32'h1);
  endtask
  // two rows; settle of 8 covers the column sync delay
  task automatic t_press();
    apb(1'b1, 8'h10, 32'h0701);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b1, 8'h00, 32'h01000019);
    key(4'h1, 5'h03, 1'b1);
    rd(8'h0c);
    chk("status", q & 32'h2ff, 32'h221);
    rd(8'h14);
    chk("event", q, 32'h031);
    rd(8'h14);
    chk("final", q, 32'h7ff);
    apb(1'b1, 8'h0c, 32'hf);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask
  // empty read, then a release leaves its final word queued
  task automatic t_release();
    rd(8'h14);
    rd(8'h0c);
    chk("underflow", q & 32'hf2, 32'h2);
    apb(1'b1, 8'h0c, 32'hf);
    key(4'h1, 5'h03, 1'b0);
    rd(8'h14);
    chk("release", q, 32'h231);
  endtask
  // clear drops the leftover word; disable frees the rows
  task automatic t_clear();
    apb(1'b1, 8'h00, 32'h0100001d);
    rd(8'h0c);
    chk("count", q & 32'hf0, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h0c);
    chk("running", q & 32'h200, 32'h0);
    chk("rows", {16'h0, row_drive_n}, 32'hffff);
  endtask
  // idle stop on a divide-by-two scan clock; two quiet scans halt it
  task automatic t_idle();
    apb(1'b1, 8'h0c, 32'hf);
    apb(1'b1, 8'h00, 32'h0001021b);
    repeat (300) @(posedge clock);
    rd(8'h0c);
    chk("idle", q & 32'h208, 32'h8);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, well past the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_press();
    t_release();
    t_clear();
    t_idle();
    report_and_stop();
  end
endmodule
`default_nettype wire
